/* hw/mpwm_top.sv */
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mpwm_top import mpwm_pkg::*; #(
  parameter int NUM_CAP = MPWM_NCAP  // Capture channels
) (
  input wire logic                 core_clk,   // 100 MHz clock
  input wire logic                 rst,        // Async reset, high
  input wire logic [7:0]           bus_addr,   // Register byte address
  input wire logic [31:0]          bus_wdata,  // Write data
  input wire logic                 bus_wr,     // Write strobe
  input wire logic                 bus_rd,     // Read strobe
  output logic [31:0]              bus_rdata,  // Read data, next cycle
  input wire logic [NUM_CAP-1:0]   cap_pin,    // Capture pins
  input wire logic                 sync_in,    // Start pulse from master
  output logic                     sync_out,   // Start pulse to slave
  output logic [MPWM_NOUT-1:0]     pwm_out,    // Pulse outputs 1..6
  output logic [MPWM_NEXT-1:0]     ext_out,    // Match-driven outputs
  output logic                     irq         // Level interrupt
);
  if (NUM_CAP < 1 || NUM_CAP > 4) begin : g_bad_cap
    $error("NUM_CAP must be 1..4");
  end
  localparam int ISW = MPWM_NMATCH + NUM_CAP;  // Status width

  // Register decode helpers
  function automatic logic is_match(input logic [7:0] a);
    return a[7:5] == MPWM_PAGE_MATCH && a[4:2] < 3'(MPWM_NMATCH);
  endfunction
  function automatic logic is_cap(input logic [7:0] a);
    return a[7:5] == MPWM_PAGE_CAP && a[4:2] < 3'(NUM_CAP);
  endfunction

  mpwm_run_e                        state_ff;     // Run state
  logic [MPWM_CTRL_W-1:0]           ctrl_ff;      // Control bits
  logic [31:0]                      presc_ff;     // Prescale limit
  logic [31:0]                      pcnt_ff;      // Prescale count
  logic [31:0]                      tc_ff;        // Main count
  logic [MPWM_NMATCH*MPWM_MC_W-1:0] mctl_ff;      // Match actions
  logic [MPWM_NOUT-1:0]             dbl_ff;       // Double-edge select
  logic [MPWM_NOUT-1:0]             oen_ff;       // Output enables
  logic [NUM_CAP*MPWM_CC_W-1:0]     cctl_ff;      // Capture config
  logic [2*MPWM_NEXT-1:0]           ectl_ff;      // External actions
  logic [ISW-1:0]                   istat_ff;     // Sticky events
  logic [ISW-1:0]                   imask_ff;     // Interrupt mask
  logic [MPWM_NEXT-1:0]             ext_ff;       // External levels
  logic [MPWM_NOUT-1:0]             out_ff;       // Pulse levels
  logic                             sync_out_ff;  // Start pulse
  logic [31:0]                      rdata_ff;     // Read data
  logic                             rd_bank_ff;   // Read came from bank
  logic [31:0]                      rd_nxt;       // Read mux
  logic [31:0]                      bank_q;       // Bank read data
  logic [MPWM_NMATCH-1:0]           rel_pend;     // Pending releases
  logic [MPWM_NMATCH-1:0][31:0]     act;          // Active matches
  logic [MPWM_NMATCH-1:0]           hit, mint, mrst, mstop;
  logic [MPWM_NOUT-1:0]             pset, pclr;   // Pulse set and clear
  logic                             run, tick_src, tick, rst_hit;
  logic                             stop_hit, apply, pwm, wr_ctrl;

  mpwm_cap_if #(.N(NUM_CAP)) cb ();

  mpwm_capture #(.N(NUM_CAP)) u_cap (
    .core_clk (core_clk),
    .rst      (rst),
    .cap_pin  (cap_pin),
    .cb       (cb.cap)
  );

  mpwm_match_bank #(.N(MPWM_NMATCH)) u_bank (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (bus_wr && is_match(bus_addr)),
    .wr_idx   (bus_addr[4:2]),
    .wr_data  (bus_wdata),
    .rel_set  ((bus_wr && bus_addr == MPWM_OFS_REL) ?
               bus_wdata[MPWM_NMATCH-1:0] : '0),
    .apply    (apply),
    .rd_idx   (bus_addr[4:2]),
    .rd_q     (bank_q),
    .rel_pend (rel_pend),
    .act      (act)
  );

  assign cb.count   = tc_ff;
  assign cb.cfg     = cctl_ff;
  assign cb.cnt_sel = ctrl_ff[MPWM_CB_CSEL +: 2];

  // Count source, prescale tick and match decode
  always_comb begin
    pwm      = ctrl_ff[MPWM_CB_PWM];
    run      = state_ff == ST_COUNT;
    tick_src = ctrl_ff[MPWM_CB_CNTM] ? cb.cnt_edge : 1'b1;
    tick     = run && tick_src && pcnt_ff == presc_ff;
    for (int i = 0; i < MPWM_NMATCH; i++) begin
      mint[i]  = mctl_ff[i*MPWM_MC_W+MPWM_MC_INT];
      mrst[i]  = mctl_ff[i*MPWM_MC_W+MPWM_MC_RST];
      mstop[i] = mctl_ff[i*MPWM_MC_W+MPWM_MC_STOP];
      hit[i]   = tick && tc_ff == act[i];
    end
    rst_hit  = |(hit & mrst) || (pwm && hit[0]);
    stop_hit = |(hit & mstop);
    // Pulse mode waits for the period restart; else immediate
    apply    = pwm ? hit[0] : 1'b1;
    wr_ctrl  = bus_wr && bus_addr == MPWM_OFS_CTRL;
  end

  // Set and clear terms of each pulse output
  always_comb begin
    for (int i = 0; i < MPWM_NOUT; i++) begin
      if (i > 0 && dbl_ff[i]) begin
        pset[i] = hit[i];
      end else begin
        // Zero width match means constant low
        pset[i] = hit[0] && act[i+1] != 32'h0;
      end
      pclr[i] = hit[i+1];
    end
  end

  // Run state; master and slave both leave armed together
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (ctrl_ff[MPWM_CB_EN]) begin
            state_ff <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (!ctrl_ff[MPWM_CB_EN]) begin
            state_ff <= ST_IDLE;
          end else if (!ctrl_ff[MPWM_CB_SLAVE] || sync_in) begin
            state_ff <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (stop_hit || !ctrl_ff[MPWM_CB_EN]) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Master sends its start pulse as it arms
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_out_ff <= 1'b0;
    end else begin
      sync_out_ff <= state_ff == ST_IDLE && ctrl_ff[MPWM_CB_EN]
                     && !ctrl_ff[MPWM_CB_SLAVE];
    end
  end

  // Control; a stop match beats a same-cycle enable write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= bus_wdata[MPWM_CTRL_W-1:0];
      end
      if (stop_hit) begin
        ctrl_ff[MPWM_CB_EN] <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      presc_ff <= MPWM_WORD_RST;
      mctl_ff  <= '0;
      dbl_ff   <= '0;
      oen_ff   <= '0;
      cctl_ff  <= '0;
      ectl_ff  <= '0;
      imask_ff <= '0;
    end else if (bus_wr) begin
      case (bus_addr)
        MPWM_OFS_PRESC: presc_ff <= bus_wdata;
        MPWM_OFS_MCTRL: mctl_ff  <= bus_wdata[MPWM_NMATCH*MPWM_MC_W-1:0];
        MPWM_OFS_PSEL: begin
          dbl_ff <= bus_wdata[MPWM_NOUT-1:0];
          oen_ff <= bus_wdata[MPWM_PS_OEN +: MPWM_NOUT];
        end
        MPWM_OFS_CCTRL: cctl_ff  <= bus_wdata[NUM_CAP*MPWM_CC_W-1:0];
        MPWM_OFS_ECTRL: ectl_ff  <= bus_wdata[2*MPWM_NEXT-1:0];
        MPWM_OFS_IMASK: imask_ff <= bus_wdata[ISW-1:0];
        default: ;  // Unmapped writes are ignored
      endcase
    end
  end

  // Prescaler and main count; reset bit holds both at zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pcnt_ff <= MPWM_WORD_RST;
      tc_ff   <= MPWM_WORD_RST;
    end else if (ctrl_ff[MPWM_CB_RST]) begin
      pcnt_ff <= MPWM_WORD_RST;
      tc_ff   <= MPWM_WORD_RST;
    end else if (run && tick_src) begin
      pcnt_ff <= tick ? 32'h0 : pcnt_ff + 32'h1;
      if (tick) begin
        tc_ff <= rst_hit ? 32'h0 : tc_ff + 32'h1;
      end
    end
  end

  // Pulse outputs; clear wins so equal edges give no glitch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_ff <= '0;
    end else begin
      for (int i = 0; i < MPWM_NOUT; i++) begin
        if (!pwm || !oen_ff[i]) begin
          out_ff[i] <= 1'b0;
        end else if (pclr[i]) begin
          out_ff[i] <= 1'b0;
        end else if (pset[i]) begin
          out_ff[i] <= 1'b1;
        end
      end
    end
  end

  // External match outputs; a direct write presets the level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_ff <= '0;
    end else if (bus_wr && bus_addr == MPWM_OFS_EOUT) begin
      ext_ff <= bus_wdata[MPWM_NEXT-1:0];
    end else begin
      for (int i = 0; i < MPWM_NEXT; i++) begin
        if (hit[i]) begin
          case (mpwm_ext_e'(ectl_ff[2*i +: 2]))
            MPWM_EXT_LOW:    ext_ff[i] <= 1'b0;
            MPWM_EXT_HIGH:   ext_ff[i] <= 1'b1;
            MPWM_EXT_TOGGLE: ext_ff[i] <= !ext_ff[i];
            default:         ext_ff[i] <= ext_ff[i];
          endcase
        end
      end
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      istat_ff <= '0;
    end else begin
      istat_ff <= (istat_ff & ~((bus_wr && bus_addr == MPWM_OFS_ISTAT) ?
                   bus_wdata[ISW-1:0] : '0))
                | {cb.evt & cb_int(cctl_ff), hit & mint};
    end
  end

  function automatic logic [NUM_CAP-1:0] cb_int(
    input logic [NUM_CAP*MPWM_CC_W-1:0] c);
    for (int i = 0; i < NUM_CAP; i++) begin
      cb_int[i] = c[i*MPWM_CC_W+MPWM_CC_INT];
    end
  endfunction

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_nxt = 32'h0;
    case (bus_addr)
      MPWM_OFS_CTRL:  rd_nxt = 32'(ctrl_ff);
      MPWM_OFS_PRESC: rd_nxt = presc_ff;
      MPWM_OFS_COUNT: rd_nxt = tc_ff;
      MPWM_OFS_PCNT:  rd_nxt = pcnt_ff;
      MPWM_OFS_MCTRL: rd_nxt = 32'(mctl_ff);
      MPWM_OFS_REL:   rd_nxt = 32'(rel_pend);
      MPWM_OFS_PSEL:  rd_nxt = 32'({oen_ff, 2'b00, dbl_ff});
      MPWM_OFS_CCTRL: rd_nxt = 32'(cctl_ff);
      MPWM_OFS_ECTRL: rd_nxt = 32'(ectl_ff);
      MPWM_OFS_ISTAT: rd_nxt = 32'(istat_ff);
      MPWM_OFS_IMASK: rd_nxt = 32'(imask_ff);
      MPWM_OFS_EOUT:  rd_nxt = 32'(ext_ff);
      default: begin
        if (is_cap(bus_addr)) begin
          rd_nxt = cb.val[bus_addr[3:2]];
        end
      end
    endcase
  end

  // Read data register; bank words come from its own register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff   <= MPWM_WORD_RST;
      rd_bank_ff <= 1'b0;
    end else begin
      rd_bank_ff <= bus_rd && is_match(bus_addr);
      if (bus_rd) begin
        rdata_ff <= rd_nxt;
      end
    end
  end

  assign bus_rdata = rd_bank_ff ? bank_q : rdata_ff;
  assign sync_out  = sync_out_ff;
  assign pwm_out   = out_ff;
  assign ext_out   = ext_ff;
  assign irq       = |(istat_ff & imask_ff);

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_prescale_wrap: assert property (
    tick && !ctrl_ff[MPWM_CB_RST] |=> pcnt_ff == 32'h0)
    else $error("prescaler did not wrap on tick");
  a_count_step: assert property (
    tick && !rst_hit && !ctrl_ff[MPWM_CB_RST] |=> tc_ff == $past(tc_ff) + 32'h1)
    else $error("count did not advance by one");
  a_period_restart: assert property (
    pwm && hit[0] |=> tc_ff == 32'h0)
    else $error("period match did not restart count");
  a_single_rise: assert property (
    pwm && oen_ff[0] && hit[0] && act[1] != 32'h0 && !hit[1] && !wr_ctrl
    |=> pwm_out[0])
    else $error("single-edge output did not rise");
  a_edge_fall: assert property (
    pwm && hit[2] |=> !pwm_out[1])
    else $error("pulse output did not fall on match");
  a_stop_idle: assert property (
    stop_hit |=> state_ff == ST_IDLE ##1 !run)
    else $error("stop match did not halt the count");
  a_timer_quiet: assert property (
    !pwm && !wr_ctrl |=> pwm_out == '0)
    else $error("pulse output active outside pulse mode");
  a_ext_toggle: assert property (
    hit[0] && ectl_ff[1:0] == 2'b11 && !bus_wr |=> ext_out[0] != $past(ext_out[0]))
    else $error("external output did not toggle");
  a_pending_set: assert property (
    hit[0] && mint[0] |=> istat_ff[0])
    else $error("match event flag not set");
  a_slave_wait: assert property (
    state_ff == ST_ARMED && ctrl_ff[MPWM_CB_SLAVE] && !sync_in |=> !run)
    else $error("slave started without sync");

  c_pwm_period: cover property (pwm && hit[0] ##[1:50] hit[1]);
  c_stop: cover property (stop_hit);
  c_irq: cover property ($rose(irq));
endmodule // mpwm_top
`default_nettype wire

/* hw/mpwm_pkg.sv */
package mpwm_pkg;
  // Block dimensions
  localparam int MPWM_NMATCH = 7;   // Match registers
  localparam int MPWM_NCAP   = 2;   // Capture channels
  localparam int MPWM_NOUT   = 6;   // Pulse outputs
  localparam int MPWM_NEXT   = 4;   // Match-driven external outputs
  // Register byte offsets
  localparam logic [7:0] MPWM_OFS_CTRL   = 8'h00;
  localparam logic [7:0] MPWM_OFS_PRESC  = 8'h04;
  localparam logic [7:0] MPWM_OFS_COUNT  = 8'h08;
  localparam logic [7:0] MPWM_OFS_PCNT   = 8'h0c;
  localparam logic [7:0] MPWM_OFS_MCTRL  = 8'h10;
  localparam logic [7:0] MPWM_OFS_REL    = 8'h14;
  localparam logic [7:0] MPWM_OFS_PSEL   = 8'h18;
  localparam logic [7:0] MPWM_OFS_CCTRL  = 8'h1c;
  localparam logic [7:0] MPWM_OFS_ECTRL  = 8'h20;
  localparam logic [7:0] MPWM_OFS_ISTAT  = 8'h24;
  localparam logic [7:0] MPWM_OFS_IMASK  = 8'h28;
  localparam logic [7:0] MPWM_OFS_EOUT   = 8'h2c;
  localparam logic [2:0] MPWM_PAGE_MATCH = 3'h2;  // 0x40..0x58
  localparam logic [2:0] MPWM_PAGE_CAP   = 3'h3;  // 0x60..0x6c
  // Control register fields
  localparam int MPWM_CB_EN    = 0;  // Counting enabled
  localparam int MPWM_CB_RST   = 1;  // Hold count and prescaler at zero
  localparam int MPWM_CB_PWM   = 2;  // Pulse mode on
  localparam int MPWM_CB_CNTM  = 3;  // Count capture-input edges
  localparam int MPWM_CB_CSEL  = 4;  // Two-bit input select
  localparam int MPWM_CB_SLAVE = 6;  // Start on partner sync pulse
  localparam int MPWM_CTRL_W   = 7;
  // Per-match control field (three bits each)
  localparam int MPWM_MC_INT  = 0;
  localparam int MPWM_MC_RST  = 1;
  localparam int MPWM_MC_STOP = 2;
  localparam int MPWM_MC_W    = 3;
  // Per-capture control field (three bits each)
  localparam int MPWM_CC_RISE = 0;
  localparam int MPWM_CC_FALL = 1;
  localparam int MPWM_CC_INT  = 2;
  localparam int MPWM_CC_W    = 3;
  localparam int MPWM_PS_OEN  = 8;   // Output enables start here
  // Reset values
  localparam logic [31:0] MPWM_WORD_RST = 32'h0;
  // External output action on match
  typedef enum logic [1:0] {
    MPWM_EXT_KEEP, MPWM_EXT_LOW, MPWM_EXT_HIGH, MPWM_EXT_TOGGLE
  } mpwm_ext_e;
  // Run state of the counter
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} mpwm_run_e;
endpackage

/* hw/mpwm_cap_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mpwm_cap_if import mpwm_pkg::*; #(parameter int N = MPWM_NCAP);
  logic [31:0]             count;     // Live count
  logic [N*MPWM_CC_W-1:0]  cfg;       // Edge and interrupt selects
  logic [1:0]              cnt_sel;   // Input used as count source
  logic [N-1:0]            evt;       // Capture pulses
  logic [N-1:0][31:0]      val;       // Captured counts
  logic                    cnt_edge;  // Count-source rising edge
  modport ctl (output count, cfg, cnt_sel, input evt, val, cnt_edge);
  modport cap (input count, cfg, cnt_sel, output evt, val, cnt_edge);
endinterface
`default_nettype wire

/* hw/mpwm_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module mpwm_capture import mpwm_pkg::*; #(
  parameter int N = MPWM_NCAP  // Channels
) (
  input wire logic         core_clk,  // Clock
  input wire logic         rst,       // Async reset
  input wire logic [N-1:0] cap_pin,   // Raw capture pins
  mpwm_cap_if.cap          cb         // Link to the counter
);
  logic [N-1:0] s1_ff, s2_ff, prev_ff;  // Synchroniser and history
  logic [N-1:0][31:0] val_ff;           // Captured counts
  logic [N-1:0] rise, fall;             // Edges seen on clean copy
  logic [3:0]   rise4;                  // Padded for safe select

  // Two flops before use, third only for edge history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      prev_ff <= '0;
    end else begin
      s1_ff   <= cap_pin;
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  // Edge decode from second stage only
  always_comb begin
    rise  = s2_ff & ~prev_ff;
    fall  = ~s2_ff & prev_ff;
    rise4 = 4'(rise);
    for (int i = 0; i < N; i++) begin
      cb.evt[i] = (rise[i] & cb.cfg[i*MPWM_CC_W+MPWM_CC_RISE])
                | (fall[i] & cb.cfg[i*MPWM_CC_W+MPWM_CC_FALL]);
    end
    cb.cnt_edge = rise4[cb.cnt_sel];
  end

  // Latch count on a selected edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      val_ff <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (cb.evt[i]) begin
          val_ff[i] <= cb.count;
        end
      end
    end
  end
  assign cb.val = val_ff;

  a_capture_latch: assert property (@(posedge core_clk) disable iff (rst)
    cb.evt[0] |=> val_ff[0] == $past(cb.count))
    else $error("capture did not latch the count");
  c_capture: cover property (@(posedge core_clk) disable iff (rst) cb.evt[0]);
endmodule // mpwm_capture
`default_nettype wire

/* hw/mpwm_match_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module mpwm_match_bank import mpwm_pkg::*; #(
  parameter int N = MPWM_NMATCH  // Match words
) (
  input wire logic             core_clk,  // Clock
  input wire logic             rst,       // Async reset
  input wire logic             wr_en,     // Shadow write
  input wire logic [2:0]       wr_idx,    // Shadow index
  input wire logic [31:0]      wr_data,   // Shadow data
  input wire logic [N-1:0]     rel_set,   // Software release bits
  input wire logic             apply,     // Safe moment to apply
  input wire logic [2:0]       rd_idx,    // Read index
  output logic [31:0]          rd_q,      // Registered read data
  output logic [N-1:0]         rel_pend,  // Released, not yet applied
  output logic [N-1:0][31:0]   act        // Values in use
);
  if (N < 2 || N > 8) begin : g_bad_n
    $error("match bank needs 2..8 words");
  end
  logic [N-1:0][31:0] shadow_ff, act_ff;  // Written vs applied
  logic [N-1:0]       pend_ff;            // Release pending
  logic [31:0]        rd_q_ff;            // Read register

  // Software writes only reach the shadow copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadow_ff <= '0;
    end else if (wr_en && {1'b0, wr_idx} < 4'(N)) begin
      shadow_ff[wr_idx] <= wr_data;
    end
  end

  // Release is held until apply; a new release wins over clearing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= rel_set | (apply ? '0 : pend_ff);
    end
  end

  // Copy released words only at the apply moment
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_ff <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (apply && pend_ff[i]) begin
          act_ff[i] <= shadow_ff[i];
        end
      end
    end
  end

  // Read port is registered, unused index gives zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_q_ff <= MPWM_WORD_RST;
    end else begin
      // Index widened by one bit so a full bank of eight still decodes
      rd_q_ff <= ({1'b0, rd_idx} < 4'(N)) ? shadow_ff[rd_idx] : MPWM_WORD_RST;
    end
  end

  assign rd_q     = rd_q_ff;
  assign rel_pend = pend_ff;
  assign act      = act_ff;

  a_release_apply: assert property (@(posedge core_clk) disable iff (rst)
    apply && pend_ff[1] |=> act_ff[1] == $past(shadow_ff[1]))
    else $error("released match value not applied");
  a_hold_unreleased: assert property (@(posedge core_clk) disable iff (rst)
    !(apply && pend_ff[2]) |=> $stable(act_ff[2]))
    else $error("match value changed without release");
endmodule // mpwm_match_bank
`default_nettype wire

/* test/mpwm_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Motor drive stage seen by pulse output 1: measures pulse and period length
module mpwm_load_model (
  input  wire logic        core_clk,  // Clock
  input  wire logic        rst,       // Async reset
  input  wire logic        drive,     // Gate drive from the pulse unit
  output logic [1:0]       sense,     // Current-sense feedback to capture pins
  output logic [31:0]      hi_len,    // Last high time in cycles
  output logic [31:0]      per_len,   // Last rise-to-rise time in cycles
  output logic [31:0]      n_rise     // Rising edges seen
);
  logic        prev_ff;  // Drive level one cycle ago
  logic [31:0] cnt_ff;   // Cycles since last rise
  logic [31:0] hcnt_ff;  // Cycles high so far
  // Sense lags drive by a cycle, like a real shunt filter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
      sense   <= 2'h0;
      cnt_ff  <= 32'h0;
      hcnt_ff <= 32'h0;
      hi_len  <= 32'h0;
      per_len <= 32'h0;
      n_rise  <= 32'h0;
    end else begin
      prev_ff <= drive;
      sense   <= {~drive, drive};
      cnt_ff  <= cnt_ff + 32'h1;
      hcnt_ff <= hcnt_ff + 32'h1;
      if (drive && !prev_ff) begin  // Rise: period ends, pulse starts
        per_len <= cnt_ff;
        cnt_ff  <= 32'h1;
        hcnt_ff <= 32'h1;
        n_rise  <= n_rise + 32'h1;
      end
      if (!drive && prev_ff) begin  // Fall: pulse width known
        hi_len <= hcnt_ff;
      end
    end
  end
endmodule // mpwm_load_model
`default_nettype wire

/* test/test_match_based_pwm_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_match_based_pwm_timer;
  import mpwm_pkg::*;
  logic core_clk, rst, bus_wr, bus_rd, irq, sync_out;  // Bench nets
  logic [7:0]  bus_addr;   // Address
  logic [31:0] bus_wdata, bus_rdata, hi_len, per_len, n_rise, rd_v, lfsr_v;
  logic [1:0]  cap_pin;    // Load feedback
  logic [5:0]  pwm_out;    // Pulse outputs
  logic [3:0]  ext_out;    // Match outputs
  int n_mismatch, n_checks, p, m0, m1, k, r0, n_sync;  // Counters and model values
  mpwm_top dut_u (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cap_pin(cap_pin),
    .sync_in(1'b0), .sync_out(sync_out), .pwm_out(pwm_out), .ext_out(ext_out), .irq(irq));
  mpwm_load_model load_u (.core_clk(core_clk), .rst(rst), .drive(pwm_out[0]), .sense(cap_pin),
    .hi_len(hi_len), .per_len(per_len), .n_rise(n_rise));
  always #5 core_clk = ~core_clk;
  // Start pulses sent towards a slave unit
  always @(posedge core_clk) if (sync_out) n_sync++;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One compare for every register or measured value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_addr <= a; bus_wdata <= d; bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask
  // Read data stands from the cycle after the strobe; match bank words stand in that cycle only
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_addr <= a; bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 rd_v = bus_rdata;
  endtask
  // Bounded wait for n further rises of output 1
  task automatic wait_rises(input int n);
    int t0;
    t0 = n_rise;
    for (int i = 0; i < 3000 && n_rise < t0 + n; i++) @(posedge core_clk);
    if (n_rise < t0 + n) begin n_mismatch++; close_out(); end
  endtask
  initial begin
    core_clk = 0; rst = 1; bus_wr = 0; bus_rd = 0; bus_addr = 8'h0; bus_wdata = 32'h0;
    n_mismatch = 0; n_checks = 0; n_sync = 0; lfsr_v = 32'h44d16317;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(MPWM_OFS_CTRL);  chk(rd_v, MPWM_WORD_RST);
    rd(MPWM_OFS_ISTAT); chk(rd_v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Random prescale, period and width; model from integers
    for (k = 0; k < 3; k++) begin
      lfsr_v = lfsr(lfsr(lfsr(lfsr_v)));
      p = lfsr_v[1:0] % 3; m0 = 4 + lfsr_v[7:4] % 12; m1 = 1 + lfsr_v[15:8] % (m0 - 1);
      // Hold count at zero first: a smaller prescale could be overrun
      wr(MPWM_OFS_CTRL, 32'h2);
      wr(MPWM_OFS_PRESC, p);
      wr(8'h40, m0); wr(8'h44, m1); wr(MPWM_OFS_REL, 32'h3);
      wr(MPWM_OFS_PSEL, 32'h100); wr(MPWM_OFS_MCTRL, 32'h1); wr(MPWM_OFS_IMASK, 32'h1);
      wr(MPWM_OFS_CTRL, 32'h5);
      wait_rises(3);
      chk(per_len, (m0 + 1) * (p + 1));
      chk(hi_len, (m1 + 1) * (p + 1));
    end
    // Match outputs toggle and set; capture holds the count from three cycles after the rise
    wr(MPWM_OFS_ECTRL, 32'hb); wr(MPWM_OFS_CCTRL, 32'h5);
    wait_rises(1); r0 = ext_out;
    wait_rises(1);
    chk({31'h0, ext_out[0] ^ r0[0]}, 32'h1);
    chk({31'h0, ext_out[1]}, 32'h1);
    rd(8'h60); chk(rd_v, 3 / (p + 1));
    rd(MPWM_OFS_ISTAT); chk(rd_v & 32'h80, 32'h80);
    // Shadow write without release must not reach the output
    wr(8'h44, 32'h0);
    wait_rises(3);
    chk(hi_len, (m1 + 1) * (p + 1));
    rd(8'h44); chk(rd_v, 32'h0);
    // Interrupt: pending, masked, cleared
    rd(MPWM_OFS_ISTAT); chk(rd_v & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(MPWM_OFS_IMASK, 32'h0);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(MPWM_OFS_CCTRL, 32'h0);
    wr(MPWM_OFS_MCTRL, 32'h0); wr(MPWM_OFS_ISTAT, 32'h1ff);
    rd(MPWM_OFS_ISTAT); chk(rd_v, 32'h0);
    // Release the zero width: the restart that applies it still raises one pulse, then constant low
    wr(MPWM_OFS_REL, 32'h2);
    wait_rises(0);
    repeat (2 * (m0 + 1) * (p + 1) + 4) @(posedge core_clk);
    r0 = n_rise;
    repeat (2 * (m0 + 1) * (p + 1)) @(posedge core_clk);
    chk(n_rise, r0);
    chk({26'h0, pwm_out}, 32'h0);
    // Stop on the period match: enable drops, count rests at zero
    wr(MPWM_OFS_MCTRL, 32'h4);
    repeat (2 * (m0 + 1) * (p + 1)) @(posedge core_clk);
    rd(MPWM_OFS_CTRL); chk(rd_v, 32'h4);
    rd(MPWM_OFS_COUNT); chk(rd_v, 32'h0);
    chk(n_sync, 32'h3);
    close_out();
  end
endmodule // test_match_based_pwm_timer
`default_nettype wire
